// ---- core/keyed_watchdog_map.svh ----
`ifndef KEYED_WATCHDOG_MAP_SVH
`define KEYED_WATCHDOG_MAP_SVH

// Byte addresses on the register bus
`define WDT_CTL_ADR      8'h00
`define WDT_CTL_CLR_ADR  8'h04
`define WDT_CTL_SET_ADR  8'h08
`define WDT_CTL_INV_ADR  8'h0c
`define WDT_STAT_ADR     8'h10
`define WDT_MASK_ADR     8'h14

// Control register fields
`define WDT_KEY_MSB      31
`define WDT_KEY_LSB      16
`define WDT_ON_BIT       15
`define WDT_PS_MSB       12
`define WDT_PS_LSB       8
`define WDT_WIN_BIT      0
`define WDT_CTL_WMASK    32'h0000_8001
`define WDT_CTL_RMASK    32'h0000_9f01

// Service key and the byte lanes of a 16-bit write to the key half
`define WDT_SERVICE_KEY  16'h5743
`define WDT_KEY_SEL      4'hc

// Reset values
`define WDT_ON_RST       1'h0
`define WDT_WIN_RST      1'h0
`define WDT_EV_RST       3'h0

// Event bits of status and mask
`define WDT_EV_TIMEOUT   0
`define WDT_EV_WAKE      1
`define WDT_EV_EARLY     2
`define WDT_EV_W         3

// Counter
`define WDT_CNT_W        32

`endif

// ---- core/keyed_watchdog_pkg.sv ----
package keyed_watchdog_pkg;

	// One classic Wishbone request as seen by the slave
	typedef struct packed {
		logic [7:0]  adr;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	// Control state: software-written bits and the run postscale caught from the configuration bits
	typedef struct packed {
		logic       on;
		logic       winen;
		logic [4:0] run_ps;
	} ctl_t;

	// Write flavours of the control register and its aliases
	typedef enum logic [1:0] {
		CTL_WR_PLAIN,
		CTL_WR_CLR,
		CTL_WR_SET,
		CTL_WR_INV
	} ctl_op_t;

endpackage

// ---- core/wdt_sync2.sv ----
`timescale 1ns/1ps
module wdt_sync2 (
	// Clock, reset and enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Asynchronous level in, synchronised level out
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'h0;
			sync_o <= 1'h0;
		end else if (ce_i) begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule // wdt_sync2

// ---- core/wdt_postscale_counter.sv ----
`timescale 1ns/1ps
`include "keyed_watchdog_map.svh"
module wdt_postscale_counter (
	// Clock, reset and enable
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	// Control
	input  wire logic                     en_i,
	input  wire logic                     tick_i,
	input  wire logic                     clear_i,
	input  wire logic [4:0]               ps_i,
	// State
	output logic [`WDT_CNT_W-1:0]         count_o,
	output logic                          expire_o,
	output logic                          win_open_o
);

	logic [`WDT_CNT_W-1:0] term_w;
	logic                  last_w;

	// Period is two to the power of the postscale value, in oscillator ticks
	assign term_w     = `WDT_CNT_W'(1) << ps_i;
	assign last_w     = (count_o + `WDT_CNT_W'(1)) >= term_w;
	// Window opens in the second half of the period
	assign win_open_o = count_o >= (term_w >> 1);

	// Count advances on oscillator ticks only; a clear beats a tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o  <= '0;
			expire_o <= 1'h0;
		end else if (ce_i) begin
			expire_o <= 1'h0;
			if (!en_i || clear_i) begin
				count_o <= '0;
			end else if (tick_i) begin
				if (last_w) begin
					count_o  <= '0;
					expire_o <= 1'h1;
				end else begin
					count_o <= count_o + `WDT_CNT_W'(1);
				end
			end
		end
	end

endmodule // wdt_postscale_counter

// ---- core/keyed_watchdog_timer.sv ----
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "keyed_watchdog_map.svh"
// Operation
// - The count advances only on edges of the low-power RC oscillator pin, never on the bus clock.
// - An enabled watchdog that expires unserviced outside Sleep and Idle asserts the device reset.
// - The period is two to the power of the postscale value, in oscillator ticks.
// - The watchdog keeps counting in Sleep and Idle and its expiry can wake the device.
// - While the watchdog is on, only an expiry or a 16-bit write of 0x5743 to bits 31-16 of the control register clears the count.
// - Bit 15 switches the watchdog on and off and resets to zero.
// - The software enable only matters while the configuration enable fuse is zero.
// - Bits 12-8 read back the run-mode postscale value taken from the configuration bits.
// - The postscale readback is loaded from the configuration bits at power-on reset.
// - Bit 0 enables windowed operation and resets to zero.
// - Bits 14-13 and 7-1 read as zero and ignore writes.
// - Offsets 0x4, 0x8 and 0xc clear, set and invert the written-one control bits.
// - The watchdog is controlled both by configuration inputs and by register writes.
module keyed_watchdog_timer (
	// Clock, reset and clock enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Oscillator pin and configuration
	input  wire logic        low_power_rc_osc_i,
	input  wire logic        config_watchdog_enable_fuse_i,
	input  wire logic [4:0]  postscale_config_bits_i,
	// Power state from the power controller
	input  wire logic        sleep_i,
	input  wire logic        idle_i,
	// Device outputs
	output logic             device_reset_o,
	output logic             wake_o,
	output logic             irq_o
);

	keyed_watchdog_pkg::wb_req_t req_w;
	keyed_watchdog_pkg::ctl_t    ctl_q;
	keyed_watchdog_pkg::ctl_op_t op_w;
	logic                        req_new_w;
	logic                        wr_w;
	logic                        ctl_hit_w;
	logic                        key_ok_w;
	logic                        en_w;
	logic                        lowpwr_w;
	logic                        osc_s;
	logic                        osc_d_q;
	logic                        tick_w;
	logic [`WDT_CNT_W-1:0]       count_w;
	logic                        expire_w;
	logic                        win_open_w;
	logic                        early_w;
	logic                        fail_w;
	logic [`WDT_EV_W-1:0]        ev_w;
	logic [`WDT_EV_W-1:0]        stat_q;
	logic [`WDT_EV_W-1:0]        mask_q;
	logic [`WDT_EV_W-1:0]        stat_clr_w;
	logic [31:0]                 ctl_rd_w;

	// Decode an address to the control flavour it reaches
	function automatic keyed_watchdog_pkg::ctl_op_t ctl_op(input logic [7:0] adr);
		unique case (adr)
			`WDT_CTL_CLR_ADR: ctl_op = keyed_watchdog_pkg::CTL_WR_CLR;
			`WDT_CTL_SET_ADR: ctl_op = keyed_watchdog_pkg::CTL_WR_SET;
			`WDT_CTL_INV_ADR: ctl_op = keyed_watchdog_pkg::CTL_WR_INV;
			default:          ctl_op = keyed_watchdog_pkg::CTL_WR_PLAIN;
		endcase
	endfunction

	// True when an address is the control register or one of its aliases
	function automatic logic is_ctl(input logic [7:0] adr);
		is_ctl = (adr == `WDT_CTL_ADR) || (adr == `WDT_CTL_CLR_ADR) ||
		         (adr == `WDT_CTL_SET_ADR) || (adr == `WDT_CTL_INV_ADR);
	endfunction

	// Bus request gathered in one carrier
	assign req_w     = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
	// Work happens once, at the edge that raises ack
	assign req_new_w = cyc_i && stb_i && !ack_o;
	assign wr_w      = req_new_w && req_w.we;
	assign ctl_hit_w = is_ctl(req_w.adr);
	assign op_w      = ctl_op(req_w.adr);

	// Exact 16-bit key write at the base offset; anything else is ignored
	assign key_ok_w = wr_w && (req_w.adr == `WDT_CTL_ADR) && (req_w.sel == `WDT_KEY_SEL) &&
	                  (req_w.dat[`WDT_KEY_MSB:`WDT_KEY_LSB] == `WDT_SERVICE_KEY);

	// Fuse forces the watchdog on; otherwise the software bit decides
	assign en_w     = config_watchdog_enable_fuse_i || ctl_q.on;
	assign lowpwr_w = sleep_i || idle_i;

	// Oscillator pin is foreign to the bus clock, so it is synchronised first
	wdt_sync2 u_osc_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i (low_power_rc_osc_i),
		.sync_o  (osc_s)
	);

	// Edge detect on the synchronised level; oscillator must run well below clk_i / 2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_d_q <= 1'h0;
		end else if (ce_i) begin
			osc_d_q <= osc_s;
		end
	end
	assign tick_w = osc_s && !osc_d_q;

	// Postscaled count; a valid key clears it
	wdt_postscale_counter u_count (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.en_i       (en_w),
		.tick_i     (tick_w),
		.clear_i    (key_ok_w),
		.ps_i       (ctl_q.run_ps),
		.count_o    (count_w),
		.expire_o   (expire_w),
		.win_open_o (win_open_w)
	);

	// In window mode a service before the window opens counts as a failure
	assign early_w = key_ok_w && en_w && ctl_q.winen && !win_open_w;
	assign fail_w  = expire_w || early_w;

	// Software bits of the control register, with alias flavours; the run postscale is
	// caught from the configuration bits while reset is held and has no other writer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q.on     <= `WDT_ON_RST;
			ctl_q.winen  <= `WDT_WIN_RST;
			ctl_q.run_ps <= postscale_config_bits_i;
		end else if (ce_i && wr_w && ctl_hit_w) begin
			if (req_w.sel[1]) begin
				unique case (op_w)
					keyed_watchdog_pkg::CTL_WR_PLAIN: ctl_q.on <= req_w.dat[`WDT_ON_BIT];
					keyed_watchdog_pkg::CTL_WR_CLR:   ctl_q.on <= ctl_q.on & ~req_w.dat[`WDT_ON_BIT];
					keyed_watchdog_pkg::CTL_WR_SET:   ctl_q.on <= ctl_q.on | req_w.dat[`WDT_ON_BIT];
					keyed_watchdog_pkg::CTL_WR_INV:   ctl_q.on <= ctl_q.on ^ req_w.dat[`WDT_ON_BIT];
				endcase
			end
			if (req_w.sel[0]) begin
				unique case (op_w)
					keyed_watchdog_pkg::CTL_WR_PLAIN: ctl_q.winen <= req_w.dat[`WDT_WIN_BIT];
					keyed_watchdog_pkg::CTL_WR_CLR:   ctl_q.winen <= ctl_q.winen & ~req_w.dat[`WDT_WIN_BIT];
					keyed_watchdog_pkg::CTL_WR_SET:   ctl_q.winen <= ctl_q.winen | req_w.dat[`WDT_WIN_BIT];
					keyed_watchdog_pkg::CTL_WR_INV:   ctl_q.winen <= ctl_q.winen ^ req_w.dat[`WDT_WIN_BIT];
				endcase
			end
		end
	end

	// Device reset and wake are one-cycle pulses chosen by power state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			device_reset_o <= 1'h0;
			wake_o         <= 1'h0;
		end else if (ce_i) begin
			device_reset_o <= fail_w && !lowpwr_w;
			wake_o         <= fail_w && lowpwr_w;
		end
	end

	// Events seen by the sticky status bits
	assign ev_w[`WDT_EV_TIMEOUT] = expire_w;
	assign ev_w[`WDT_EV_WAKE]    = fail_w && lowpwr_w;
	assign ev_w[`WDT_EV_EARLY]   = early_w;
	assign stat_clr_w = (wr_w && req_w.adr == `WDT_STAT_ADR && req_w.sel[0]) ?
	                    req_w.dat[`WDT_EV_W-1:0] : '0;

	// Write-one-to-clear status; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= `WDT_EV_RST;
		end else if (ce_i) begin
			stat_q <= (stat_q & ~stat_clr_w) | ev_w;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= `WDT_EV_RST;
		end else if (ce_i && wr_w && req_w.adr == `WDT_MASK_ADR && req_w.sel[0]) begin
			mask_q <= req_w.dat[`WDT_EV_W-1:0];
		end
	end

	// Level interrupt while any unmasked status bit stands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'h0;
		end else if (ce_i) begin
			irq_o <= |(((stat_q & ~stat_clr_w) | ev_w) & mask_q);
		end
	end

	// Control readback: key half and unimplemented bits stay zero
	always_comb begin
		ctl_rd_w                          = '0;
		ctl_rd_w[`WDT_ON_BIT]             = ctl_q.on;
		ctl_rd_w[`WDT_PS_MSB:`WDT_PS_LSB] = ctl_q.run_ps;
		ctl_rd_w[`WDT_WIN_BIT]            = ctl_q.winen;
	end

	// Single-wait-state ack; unmapped reads return zero and writes there are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'h0;
			dat_o <= '0;
		end else if (ce_i) begin
			ack_o <= req_new_w;
			if (req_new_w && !req_w.we) begin
				if (ctl_hit_w) begin
					dat_o <= ctl_rd_w;
				end else if (req_w.adr == `WDT_STAT_ADR) begin
					dat_o <= {{(32-`WDT_EV_W){1'b0}}, stat_q};
				end else if (req_w.adr == `WDT_MASK_ADR) begin
					dat_o <= {{(32-`WDT_EV_W){1'b0}}, mask_q};
				end else begin
					dat_o <= '0;
				end
			end
		end
	end

	// Checks run only on edges where the block is not frozen
	default clocking cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence s_key_write;
		key_ok_w;
	endsequence

	sequence s_expire_run;
		expire_w && !lowpwr_w;
	endsequence

	sequence s_expire_low;
		expire_w && lowpwr_w;
	endsequence

	property p_key_clears;
		s_key_write ##0 en_w |=> (count_w == '0);
	endproperty
	a_key_clears: assert property (p_key_clears) else $error("Key write did not clear count");

	property p_bad_key_holds;
		wr_w && req_w.adr == `WDT_CTL_ADR && !key_ok_w && !tick_w && en_w |=> $stable(count_w);
	endproperty
	a_bad_key_holds: assert property (p_bad_key_holds) else $error("Bad key moved count");

	property p_tick_only;
		!tick_w && !key_ok_w && en_w ##1 en_w |-> $stable(count_w);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("Count moved without tick");

	property p_timeout_reset;
		s_expire_run |=> device_reset_o && !wake_o ##1 !device_reset_o;
	endproperty
	a_timeout_reset: assert property (p_timeout_reset) else $error("Expiry gave no reset");

	property p_sleep_wake;
		s_expire_low |=> wake_o && !device_reset_o;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("Expiry in low power not a wake");

	property p_period;
		en_w && tick_w && count_w == (`WDT_CNT_W'(1) << ctl_q.run_ps) - `WDT_CNT_W'(1) && !key_ok_w
			|=> expire_w;
	endproperty
	a_period: assert property (p_period) else $error("No expiry at end of period");

	property p_fuse;
		config_watchdog_enable_fuse_i |-> en_w;
	endproperty
	a_fuse: assert property (p_fuse) else $error("Fuse did not force enable");

	property p_off_idle;
		!en_w [*2] |-> count_w == '0 && !expire_w;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("Disabled watchdog counting");

	property p_rd_zero;
		ack_o && !we_i && is_ctl(adr_i) |-> dat_o[31:16] == 16'h0 && dat_o[14:13] == 2'h0 && dat_o[7:1] == 7'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("Unimplemented bits read nonzero");

	property p_ps_fixed;
		##1 $stable(ctl_q.run_ps);
	endproperty
	a_ps_fixed: assert property (p_ps_fixed) else $error("Postscale changed outside reset");

	property p_set_alias;
		wr_w && req_w.adr == `WDT_CTL_SET_ADR && req_w.sel[1] && req_w.dat[`WDT_ON_BIT] |=> ctl_q.on;
	endproperty
	a_set_alias: assert property (p_set_alias) else $error("Set alias did not set on bit");

	property p_early;
		key_ok_w && en_w && ctl_q.winen && !win_open_w && !lowpwr_w |=> device_reset_o;
	endproperty
	a_early: assert property (p_early) else $error("Early service in window mode ignored");

	property p_set_wins;
		ev_w[`WDT_EV_TIMEOUT] && stat_clr_w[`WDT_EV_TIMEOUT] |=> stat_q[`WDT_EV_TIMEOUT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Clear beat a new event");

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held two cycles");

	property p_ack_answer;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("Request not acknowledged");

	property p_late_service;
		key_ok_w && en_w && win_open_w && !expire_w |=> !device_reset_o && !wake_o;
	endproperty
	a_late_service: assert property (p_late_service) else $error("Service in open window failed");

	property p_stat_w1c;
		stat_clr_w[`WDT_EV_TIMEOUT] && !ev_w[`WDT_EV_TIMEOUT] |=> !stat_q[`WDT_EV_TIMEOUT];
	endproperty
	a_stat_w1c: assert property (p_stat_w1c) else $error("Status bit not cleared by one");

	// The interrupt lags mask changes by a cycle, so only a settled mask is checked
	property p_irq_level;
		$stable(mask_q) |-> irq_o == |(stat_q & mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

endmodule // keyed_watchdog_timer

// ---- tb/keyed_watchdog_timer_test.sv ----
`timescale 1ns/1ps
`include "keyed_watchdog_map.svh"
module keyed_watchdog_timer_test;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic [7:0]  adr_i;
	logic        we_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        osc_i;
	logic        fuse_i;
	logic        sleep_i;
	logic        idle_i;
	logic        device_reset_o;
	logic        wake_o;
	logic        irq_o;
	logic [31:0] rd;
	int          errors;
	int          num_checks;
	int          n_rst;
	int          n_wake;
	int          cycles;
	int          r0;
	int          w0;

	// Device under test; clock enable tied high so every flop runs
	keyed_watchdog_timer u_keyed_watchdog_timer (
		.clk_i                         (clk_i),
		.rst_i                         (rst_i),
		.ce_i                          (1'b1),
		.cyc_i                         (cyc_i),
		.stb_i                         (stb_i),
		.adr_i                         (adr_i),
		.we_i                          (we_i),
		.sel_i                         (sel_i),
		.dat_i                         (dat_i),
		.dat_o                         (dat_o),
		.ack_o                         (ack_o),
		.low_power_rc_osc_i            (osc_i),
		.config_watchdog_enable_fuse_i (fuse_i),
		.postscale_config_bits_i       (5'h02),
		.sleep_i                       (sleep_i),
		.idle_i                        (idle_i),
		.device_reset_o                (device_reset_o),
		.wake_o                        (wake_o),
		.irq_o                         (irq_o)
	);

	// 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Pulse counters and hang guard; the whole run needs well under 5000 cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (device_reset_o === 1'b1) n_rst <= n_rst + 1;
		if (wake_o === 1'b1) n_wake <= n_wake + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic single cycle: hold until ack is sampled high, then release
	task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i  <= w;
		sel_i <= s;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	// Oscillator edges, slow against the bus clock; settles long enough for a pulse
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_i);
			osc_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			osc_i <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		repeat (5) @(posedge clk_i);
	endtask

	task automatic service();
		wb(`WDT_CTL_ADR, 1'b1, `WDT_KEY_SEL, {`WDT_SERVICE_KEY, 16'h0000});
		r0 = n_rst;
	endtask

	task automatic test_regs();
		wb(`WDT_CTL_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0000_0200);
		wb(`WDT_CTL_ADR, 1'b1, 4'hf, 32'hffff_ffff);
		wb(`WDT_CTL_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0000_8201);
		wb(`WDT_CTL_CLR_ADR, 1'b1, 4'hf, 32'h0000_ffff);
		wb(`WDT_CTL_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0000_0200);
		wb(`WDT_CTL_SET_ADR, 1'b1, 4'hf, 32'h0000_0001);
		wb(`WDT_CTL_SET_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0000_0201);
		wb(`WDT_CTL_INV_ADR, 1'b1, 4'hf, 32'h0000_8001);
		wb(`WDT_CTL_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0000_8200);
		wb(`WDT_CTL_CLR_ADR, 1'b1, 4'hf, 32'h0000_8000);
		wb(8'h20, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0);
	endtask

	task automatic test_period();
		wb(`WDT_CTL_SET_ADR, 1'b1, 4'hf, 32'h0000_8000);
		service();
		ticks(3);
		check(n_rst - r0, 0);
		ticks(1);
		check(n_rst - r0, 1);
		check({31'h0, irq_o}, 32'h0);
		wb(`WDT_MASK_ADR, 1'b1, 4'hf, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h1);
		wb(`WDT_STAT_ADR, 1'b1, 4'hf, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		wb(`WDT_STAT_ADR, 1'b0, 4'hf, 32'h0);
		check(rd, 32'h0);
	endtask

	// Wrong value, whole-word and single-lane key writes must not clear the count
	task automatic test_service();
		service();
		ticks(3);
		service();
		ticks(3);
		check(n_rst - r0, 0);
		ticks(1);
		check(n_rst - r0, 1);
		service();
		ticks(2);
		wb(`WDT_CTL_ADR, 1'b1, `WDT_KEY_SEL, 32'h5744_0000);
		wb(`WDT_CTL_ADR, 1'b1, 4'hf, {`WDT_SERVICE_KEY, 16'h8000});
		wb(`WDT_CTL_ADR, 1'b1, 4'h8, {`WDT_SERVICE_KEY, 16'h0000});
		wb(`WDT_CTL_SET_ADR, 1'b1, `WDT_KEY_SEL, {`WDT_SERVICE_KEY, 16'h0000});
		ticks(2);
		check(n_rst - r0, 1);
	endtask

	// Sleep then Idle: expiry wakes instead of resetting
	task automatic test_sleep();
		w0 = n_wake;
		for (int k = 0; k < 2; k++) begin
			sleep_i <= (k == 0);
			idle_i  <= (k == 1);
			service();
			ticks(4);
		end
		check(n_rst - r0, 0);
		check(n_wake - w0, 2);
		wb(`WDT_STAT_ADR, 1'b0, 4'hf, 32'h0);
		check(rd & 32'h2, 32'h2);
		sleep_i <= 1'b0;
		idle_i  <= 1'b0;
	endtask

	task automatic test_fuse();
		wb(`WDT_CTL_CLR_ADR, 1'b1, 4'hf, 32'h0000_8000);
		fuse_i <= 1'b1;
		service();
		ticks(4);
		check(n_rst - r0, 1);
		fuse_i <= 1'b0;
		r0 = n_rst;
		ticks(4);
		check(n_rst - r0, 0);
	endtask

	// Servicing right after a clear falls inside the closed window
	task automatic test_window();
		wb(`WDT_CTL_SET_ADR, 1'b1, 4'hf, 32'h0000_8001);
		service();
		repeat (4) @(posedge clk_i);
		check(n_rst - r0, 1);
		ticks(2);
		service();
		repeat (4) @(posedge clk_i);
		check(n_rst - r0, 0);
		wb(`WDT_CTL_CLR_ADR, 1'b1, 4'hf, 32'h0000_8001);
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		errors = 0;
		num_checks = 0;
		n_rst = 0;
		n_wake = 0;
		cycles = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		adr_i = 8'h00;
		we_i = 1'b0;
		sel_i = 4'h0;
		dat_i = 32'h0;
		osc_i = 1'b0;
		fuse_i = 1'b0;
		sleep_i = 1'b0;
		idle_i = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		test_regs();
		test_period();
		test_service();
		test_sleep();
		test_fuse();
		test_window();
		results();
	end
endmodule // keyed_watchdog_timer_test
